/* mcr_pkg.sv */
// Purpose: Shared constants and types for the maintenance command registers
// Assumes: 16-bit register words, upper word at even address, lower at odd
// Notes: Command values are 32 bits built from an upper and a lower word
package mcr_pkg;

  localparam int unsigned CMD_COUNT = 10;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CMD_W = 32;
  localparam int unsigned ALARM_W = 8;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned SENSOR_W = 4;
  localparam int unsigned OUT_W = 16;

  // Register addresses (upper word of each command pair; the last is the final lower word)
  localparam logic [ADDR_W-1:0] ALARM_RESET_CMD_ADDR = 16'h0180;
  localparam logic [ADDR_W-1:0] ABS_POSITION_ERROR_RESET_CMD_ADDR = 16'h0182;
  localparam logic [ADDR_W-1:0] ALARM_HISTORY_CLEAR_CMD_ADDR = 16'h0184;
  localparam logic [ADDR_W-1:0] WARNING_HISTORY_CLEAR_CMD_ADDR = 16'h0186;
  localparam logic [ADDR_W-1:0] COMM_ERROR_HISTORY_CLEAR_CMD_ADDR = 16'h0188;
  localparam logic [ADDR_W-1:0] COMMAND_POSITION_PRESET_CMD_ADDR = 16'h018a;
  localparam logic [ADDR_W-1:0] PARAMETER_RECALC_CMD_ADDR = 16'h018c;
  localparam logic [ADDR_W-1:0] FACTORY_DEFAULTS_CMD_ADDR = 16'h018e;
  localparam logic [ADDR_W-1:0] NVM_LOAD_TO_RAM_CMD_ADDR = 16'h0190;
  localparam logic [ADDR_W-1:0] RAM_STORE_TO_NVM_CMD_ADDR = 16'h0192;
  localparam logic [ADDR_W-1:0] CMD_LAST_ADDR = 16'h0193;

  // Command indices, address order
  typedef enum logic [3:0] {
    MCR_ALARM_RESET,
    MCR_ABS_ERR_RESET,
    MCR_ALARM_HIST_CLR,
    MCR_WARN_HIST_CLR,
    MCR_COMM_HIST_CLR,
    MCR_POS_PRESET,
    MCR_RECALC,
    MCR_DEFAULTS,
    MCR_NVM_LOAD,
    MCR_NVM_STORE
  } mcr_cmd_e;

  // Legal command values
  localparam logic [CMD_W-1:0] CMD_VALUE_MAX = 32'h0000_0001;

  // Alarm classes that a general alarm reset may clear; bit 0 is the
  // absolute-position error, bit 7 a class that no reset clears
  localparam logic [ALARM_W-1:0] ALARM_RESETTABLE_MASK = 8'h7e;
  localparam logic [ALARM_W-1:0] ABS_POS_ERROR_BIT = 8'h01;

  // Settings kept by full initialisation: parity, stop bits, answer wait
  localparam logic [2:0] DEFAULTS_KEEP_MASK = 3'h7;

  // Time the setup takes while configuration runs
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CFG_TIME_NS = 10000;
  localparam int unsigned CFG_CYCLES_INT = (CFG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] CFG_CYCLES = 12'(CFG_CYCLES_INT);

  // Reset values
  localparam logic [WORD_W-1:0] UPPER_HOLD_RESET = 16'h0000;
  localparam logic [CMD_COUNT-1:0] CMD_STATE_RESET = 10'h000;

  typedef enum {
    MCR_CFG_IDLE,
    MCR_CFG_RUN,
    MCR_CFG_DONE
  } mcr_cfg_state_e;

endpackage

/* mcr_cmd_edge.sv */
// Purpose: Keeps the stored value of each command and flags 0-to-1 writes
// Assumes: Only values 0 and 1 reach this module
// Notes: One pulse per accepted rising write
module mcr_cmd_edge
  import mcr_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Decoded write
  input wire logic i_wr,
  input wire logic [3:0] i_idx,
  input wire logic i_value,
  // Trigger pulses
  output logic [mcr_pkg::CMD_COUNT-1:0] o_fire
);
  import mcr_pkg::*;

  typedef struct packed {
    logic [CMD_COUNT-1:0] value;
    logic [CMD_COUNT-1:0] fire;
  } mcr_edge_s;

  mcr_edge_s st_reg;
  mcr_edge_s st_next;
  logic [CMD_COUNT-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < CMD_COUNT; g++) begin : g_cmd
      assign hit[g] = i_wr && (i_idx == 4'(g));
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    // A write of 0 only rearms; only a 0-to-1 change fires
    st_next.fire = hit & ~st_reg.value & {CMD_COUNT{i_value}};
    st_next.value = (st_reg.value & ~hit) | (hit & {CMD_COUNT{i_value}});
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      st_reg <= '{value: CMD_STATE_RESET, fire: CMD_STATE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_fire = st_reg.fire;

endmodule

/* mcr_cfg_seq.sv */
// Purpose: Runs the configuration sequence when its preconditions hold
// Assumes: Precondition inputs are already synchronised
// Notes: A refused trigger leaves everything as it was
module mcr_cfg_seq
  import mcr_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Trigger and preconditions
  input wire logic i_start,
  input wire logic i_alarm_any,
  input wire logic i_moving,
  input wire logic i_tool_busy,
  // Sequence state
  output logic o_busy,
  output logic o_recalc,
  output logic o_done,
  output logic o_refused
);
  import mcr_pkg::*;

  typedef struct packed {
    mcr_cfg_state_e state;
    logic [11:0] count;
    logic recalc;
    logic done;
    logic refused;
  } mcr_cfg_s;

  mcr_cfg_s st_reg;
  mcr_cfg_s st_next;
  logic ok;

  assign ok = !i_alarm_any && !i_moving && !i_tool_busy;

  always_comb begin
    st_next = st_reg;
    st_next.recalc = 1'b0;
    st_next.done = 1'b0;
    st_next.refused = 1'b0;
    unique case (st_reg.state)
      MCR_CFG_IDLE: begin
        if (i_start && ok) begin
          st_next.state = MCR_CFG_RUN;
          st_next.count = CFG_CYCLES;
          st_next.recalc = 1'b1;
        end else if (i_start) begin
          st_next.refused = 1'b1;
        end
      end
      MCR_CFG_RUN: begin
        if (st_reg.count == 12'h001) begin
          st_next.state = MCR_CFG_DONE;
        end
        st_next.count = st_reg.count - 12'h001;
      end
      MCR_CFG_DONE: begin
        st_next.state = MCR_CFG_IDLE;
        st_next.done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      st_reg <= '{state: MCR_CFG_IDLE, count: 12'h000, recalc: 1'b0, done: 1'b0,
                  refused: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_busy = (st_reg.state != MCR_CFG_IDLE);
  assign o_recalc = st_reg.recalc;
  assign o_done = st_reg.done;
  assign o_refused = st_reg.refused;

endmodule

/* mcr_maint_top.sv */
// Purpose: Maintenance command registers of a motor driver controller
// Assumes: Register words arrive already deframed from the serial link
// Notes: All commands are write-only; pins are synchronised on entry
// Function
// - Commands act only on a 0-to-1 write; legal values are 0 and 1.
// - Alarm reset clears present alarms, except classes that stay.
// - Dedicated reset clears the absolute-position error alarm.
// - Clear-alarm-history erases all past alarm records.
// - Clear-warning-history erases all past warning records.
// - Clear-comm-error-history erases stored communication error codes.
// - Position preset loads the command position counter with the preset.
// - Configuration recomputes parameters and redoes driver setup.
// - Full initialisation restores stored data and parameters to defaults.
// - Full initialisation keeps parity, stop bits and answer wait time.
// - Batch load copies stored data into working RAM, overwriting it.
// - Batch store copies working RAM parameters into non-volatile storage.
// - Configuration runs only with no alarm, no motion, no tool busy.
// - During configuration: brake held, motor off, power lit, fault off.
// - During configuration inputs and sensors ignored, outputs undefined.
// - After configuration indicators and outputs follow real condition.
// - No automatic return move directly after configuration.
module mcr_maint_top
  import mcr_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Register word writes
  input wire logic I_REG_WR,
  input wire logic [mcr_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic [mcr_pkg::WORD_W-1:0] I_REG_WDATA,
  output logic O_REG_ACK,
  output logic O_REG_ERR,
  // Driver condition pins
  input wire logic [mcr_pkg::ALARM_W-1:0] I_ALARM_ACTIVE,
  input wire logic I_MOTOR_MOVING,
  input wire logic I_TOOL_BUSY,
  input wire logic I_BRAKE_HOLD_REQ,
  input wire logic I_EXCITE_REQ,
  input wire logic I_POWER_OK,
  input wire logic I_AUTO_RETURN_COND,
  input wire logic [mcr_pkg::CTRL_W-1:0] I_CTRL_IN,
  input wire logic [mcr_pkg::SENSOR_W-1:0] I_SENSOR_IN,
  input wire logic [mcr_pkg::OUT_W-1:0] I_SIG_OUT,
  // Maintenance actions
  output logic [mcr_pkg::ALARM_W-1:0] O_ALARM_CLEAR,
  output logic O_ALARM_HIST_CLEAR,
  output logic O_WARN_HIST_CLEAR,
  output logic O_COMM_HIST_CLEAR,
  output logic O_POS_PRESET_LOAD,
  output logic O_PARAM_RECALC,
  output logic O_DEFAULTS_RESTORE,
  output logic [2:0] O_DEFAULTS_KEEP,
  output logic O_NVM_LOAD,
  output logic O_NVM_STORE,
  // Driver state during configuration
  output logic O_CFG_BUSY,
  output logic O_CFG_REFUSED,
  output logic O_BRAKE_HOLD,
  output logic O_EXCITE,
  output logic O_POWER_INDICATOR,
  output logic O_FAULT_INDICATOR,
  output logic O_AUTO_RETURN_ALLOW,
  output logic [mcr_pkg::CTRL_W-1:0] O_CTRL_IN,
  output logic [mcr_pkg::SENSOR_W-1:0] O_SENSOR_IN,
  output logic [mcr_pkg::OUT_W-1:0] O_SIG_OUT
);
  import mcr_pkg::*;

  localparam int unsigned PIN_W = ALARM_W + 6 + CTRL_W + SENSOR_W + OUT_W;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [WORD_W-1:0] upper_hold;
    logic ack;
    logic err;
    logic [ALARM_W-1:0] alarm_clear;
    logic alarm_hist_clr;
    logic warn_hist_clr;
    logic comm_hist_clr;
    logic pos_load;
    logic defaults;
    logic nvm_load;
    logic nvm_store;
    logic ret_inhibit;
    logic brake;
    logic excite;
    logic power_ind;
    logic fault_ind;
    logic ret_allow;
    logic [CTRL_W-1:0] ctrl;
    logic [SENSOR_W-1:0] sensor;
    logic [OUT_W-1:0] sig_out;
  } mcr_top_s;

  mcr_top_s st_reg;
  mcr_top_s st_next;

  logic [PIN_W-1:0] pins;
  logic [ALARM_W-1:0] s_alarm;
  logic s_moving;
  logic s_tool;
  logic s_brake;
  logic s_excite;
  logic s_power;
  logic s_ret_cond;
  logic [CTRL_W-1:0] s_ctrl;
  logic [SENSOR_W-1:0] s_sensor;
  logic [OUT_W-1:0] s_sig_out;
  logic [ADDR_W-1:0] rel_addr;
  logic in_range;
  logic [CMD_W-1:0] full_value;
  logic value_ok;
  logic cmd_wr;
  logic [3:0] cmd_idx;
  logic [CMD_COUNT-1:0] fire;
  logic cfg_busy;
  logic cfg_recalc;
  logic cfg_done;
  logic cfg_refused;

  assign pins = {I_ALARM_ACTIVE, I_MOTOR_MOVING, I_TOOL_BUSY, I_BRAKE_HOLD_REQ,
                 I_EXCITE_REQ, I_POWER_OK, I_AUTO_RETURN_COND, I_CTRL_IN,
                 I_SENSOR_IN, I_SIG_OUT};
  assign {s_alarm, s_moving, s_tool, s_brake, s_excite, s_power, s_ret_cond,
          s_ctrl, s_sensor, s_sig_out} = st_reg.sync2;

  // Upper word is held until its lower word completes the 32-bit value
  assign rel_addr = I_REG_ADDR - ALARM_RESET_CMD_ADDR;
  assign in_range = (I_REG_ADDR >= ALARM_RESET_CMD_ADDR) && (I_REG_ADDR <= CMD_LAST_ADDR);
  assign full_value = {st_reg.upper_hold, I_REG_WDATA};
  assign value_ok = (full_value <= CMD_VALUE_MAX);
  assign cmd_wr = I_REG_WR && in_range && I_REG_ADDR[0] && value_ok;
  assign cmd_idx = rel_addr[4:1];

  mcr_cmd_edge u_edge (
    .I_MCLK(I_MCLK),
    .I_RESET(I_RESET),
    .i_wr(cmd_wr),
    .i_idx(cmd_idx),
    .i_value(full_value[0]),
    .o_fire(fire)
  );

  mcr_cfg_seq u_cfg (
    .I_MCLK(I_MCLK),
    .I_RESET(I_RESET),
    .i_start(fire[MCR_RECALC]),
    .i_alarm_any(|s_alarm),
    .i_moving(s_moving),
    .i_tool_busy(s_tool),
    .o_busy(cfg_busy),
    .o_recalc(cfg_recalc),
    .o_done(cfg_done),
    .o_refused(cfg_refused)
  );

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    if (I_REG_WR) begin
      if (!in_range) begin
        st_next.err = 1'b1;
      end else if (!I_REG_ADDR[0]) begin
        st_next.upper_hold = I_REG_WDATA;
        st_next.ack = 1'b1;
      end else begin
        // Values other than 0 and 1 are rejected and change no command; the held upper word clears
        st_next.upper_hold = UPPER_HOLD_RESET;
        st_next.ack = value_ok;
        st_next.err = !value_ok;
      end
    end
    // Absolute-position error needs its own command
    st_next.alarm_clear = ({ALARM_W{fire[MCR_ALARM_RESET]}} & ALARM_RESETTABLE_MASK)
                        | ({ALARM_W{fire[MCR_ABS_ERR_RESET]}} & ABS_POS_ERROR_BIT);
    st_next.alarm_hist_clr = fire[MCR_ALARM_HIST_CLR];
    st_next.warn_hist_clr = fire[MCR_WARN_HIST_CLR];
    st_next.comm_hist_clr = fire[MCR_COMM_HIST_CLR];
    st_next.pos_load = fire[MCR_POS_PRESET];
    st_next.defaults = fire[MCR_DEFAULTS];
    st_next.nvm_load = fire[MCR_NVM_LOAD];
    st_next.nvm_store = fire[MCR_NVM_STORE];
    // Suppress the return move until its condition drops once
    if (cfg_done && s_ret_cond) begin
      st_next.ret_inhibit = 1'b1;
    end else if (!s_ret_cond) begin
      st_next.ret_inhibit = 1'b0;
    end
    st_next.ret_allow = s_ret_cond && !st_next.ret_inhibit && !cfg_busy;
    if (cfg_busy) begin
      st_next.brake = 1'b1;
      st_next.excite = 1'b0;
      st_next.power_ind = 1'b1;
      st_next.fault_ind = 1'b0;
      // Zero rather than held so no stale start reaches the motion logic
      st_next.ctrl = '0;
      st_next.sensor = '0;
      st_next.sig_out = '0;
    end else begin
      st_next.brake = s_brake;
      st_next.excite = s_excite;
      st_next.power_ind = s_power;
      st_next.fault_ind = |s_alarm;
      st_next.ctrl = s_ctrl;
      st_next.sensor = s_sensor;
      st_next.sig_out = s_sig_out;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign O_REG_ACK = st_reg.ack;
  assign O_REG_ERR = st_reg.err;
  assign O_ALARM_CLEAR = st_reg.alarm_clear;
  assign O_ALARM_HIST_CLEAR = st_reg.alarm_hist_clr;
  assign O_WARN_HIST_CLEAR = st_reg.warn_hist_clr;
  assign O_COMM_HIST_CLEAR = st_reg.comm_hist_clr;
  assign O_POS_PRESET_LOAD = st_reg.pos_load;
  assign O_PARAM_RECALC = cfg_recalc;
  assign O_DEFAULTS_RESTORE = st_reg.defaults;
  assign O_DEFAULTS_KEEP = DEFAULTS_KEEP_MASK;
  assign O_NVM_LOAD = st_reg.nvm_load;
  assign O_NVM_STORE = st_reg.nvm_store;
  assign O_CFG_BUSY = cfg_busy;
  assign O_CFG_REFUSED = cfg_refused;
  assign O_BRAKE_HOLD = st_reg.brake;
  assign O_EXCITE = st_reg.excite;
  assign O_POWER_INDICATOR = st_reg.power_ind;
  assign O_FAULT_INDICATOR = st_reg.fault_ind;
  assign O_AUTO_RETURN_ALLOW = st_reg.ret_allow;
  assign O_CTRL_IN = st_reg.ctrl;
  assign O_SENSOR_IN = st_reg.sensor;
  assign O_SIG_OUT = st_reg.sig_out;

endmodule

/* mcr_maint_top_props.sv */
// Purpose: Port assertions for the maintenance command registers
// Assumes: Answer one cycle and action two cycles after the taking edge
// Notes: Bound to the top module below
module mcr_maint_props
  import mcr_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Watched ports
  input wire logic I_REG_WR,
  input wire logic [mcr_pkg::ADDR_W-1:0] I_REG_ADDR,
  input wire logic I_AUTO_RETURN_COND,
  input wire logic O_REG_ACK,
  input wire logic O_REG_ERR,
  input wire logic [mcr_pkg::ALARM_W-1:0] O_ALARM_CLEAR,
  input wire logic O_NVM_STORE,
  input wire logic O_PARAM_RECALC,
  input wire logic [2:0] O_DEFAULTS_KEEP,
  input wire logic O_CFG_BUSY,
  input wire logic O_BRAKE_HOLD,
  input wire logic O_EXCITE,
  input wire logic O_POWER_INDICATOR,
  input wire logic O_FAULT_INDICATOR,
  input wire logic O_AUTO_RETURN_ALLOW,
  input wire logic [mcr_pkg::CTRL_W-1:0] O_CTRL_IN,
  input wire logic [mcr_pkg::SENSOR_W-1:0] O_SENSOR_IN
);
  default clocking @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);
  logic [11:0] busy_len_reg;
  logic [11:0] busy_len_next;
  // Length of the current busy run, cleared once busy drops
  always_comb busy_len_next = O_CFG_BUSY ? busy_len_reg + 12'h001 : 12'h000;
  always_ff @(posedge I_MCLK) busy_len_reg <= I_RESET ? 12'h000 : busy_len_next;

  a_write_answered:
    assert property (I_REG_WR |=> O_REG_ACK != O_REG_ERR)
    else $error("write answered by neither or both");
  a_unmapped_err:
    assert property (I_REG_WR && (I_REG_ADDR < 16'h0180 || I_REG_ADDR > 16'h0193)
      |=> O_REG_ERR) else $error("unmapped write not refused");
  a_clear_cause:
    assert property (O_ALARM_CLEAR != 8'h00 |-> !O_ALARM_CLEAR[7] && $past(I_REG_WR, 2)
      && $past(I_REG_ADDR, 2) == (O_ALARM_CLEAR[0] ? 16'h0183 : 16'h0181))
    else $error("alarm clear without its command");
  a_store_cause:
    assert property (O_NVM_STORE |-> $past(I_REG_WR, 2) && $past(I_REG_ADDR, 2) == 16'h0193)
    else $error("store without its command");
  a_keep_settings:
    assert property (O_DEFAULTS_KEEP == 3'h7) else $error("link settings not kept");
  a_recalc_starts:
    assert property (O_PARAM_RECALC |-> O_CFG_BUSY && !$past(O_CFG_BUSY))
    else $error("recalc without busy start");
  a_busy_length:
    assert property ($fell(O_CFG_BUSY) |-> busy_len_reg == CFG_CYCLES + 12'h001)
    else $error("busy run length wrong");
  a_safe_hold:
    assert property (O_CFG_BUSY && $past(O_CFG_BUSY) |-> O_BRAKE_HOLD && !O_EXCITE
      && O_POWER_INDICATOR && !O_FAULT_INDICATOR) else $error("unsafe state while busy");
  a_inputs_masked:
    assert property (O_CFG_BUSY && $past(O_CFG_BUSY) |-> O_CTRL_IN == 16'h0000
      && O_SENSOR_IN == 4'h0) else $error("inputs passed while busy");
  a_no_return:
    assert property ($fell(O_CFG_BUSY) && I_AUTO_RETURN_COND |-> !O_AUTO_RETURN_ALLOW [*3])
    else $error("return allowed right after setup");
endmodule

bind mcr_maint_top mcr_maint_props i_mcr_maint_props (
  .I_MCLK, .I_RESET, .I_REG_WR, .I_REG_ADDR, .I_AUTO_RETURN_COND, .O_REG_ACK, .O_REG_ERR,
  .O_ALARM_CLEAR, .O_NVM_STORE, .O_PARAM_RECALC, .O_DEFAULTS_KEEP, .O_CFG_BUSY,
  .O_BRAKE_HOLD, .O_EXCITE, .O_POWER_INDICATOR, .O_FAULT_INDICATOR, .O_AUTO_RETURN_ALLOW,
  .O_CTRL_IN, .O_SENSOR_IN
);

/* mcr_host_model.sv */
// Purpose: Host side that writes register words to the device
// Assumes: Device answers one cycle after the taking edge
// Notes: Never reads back, so no value seen during setup is trusted
module mcr_host_model
  import mcr_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Answer
  input wire logic i_ack,
  input wire logic i_err,
  // Word writes
  output logic o_wr,
  output logic [mcr_pkg::ADDR_W-1:0] o_addr,
  output logic [mcr_pkg::WORD_W-1:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 16'hffff;
  end
  // Released lines show the inverse so stale data can never pass as valid
  task automatic put_word(input logic [15:0] a, input logic [15:0] d, output logic [1:0] r);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    r = {i_ack, i_err};
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

/* test_mcr_maint_top.sv */
// Purpose: Self-checking bench for the maintenance command registers
// Assumes: Commands written upper word first through the host model
// Notes: Action pulses are counted at each edge; exact latency is the checker's job
module test_mcr_maint_top
  import mcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_MCLK, I_RESET, I_REG_WR, O_REG_ACK, O_REG_ERR, I_MOTOR_MOVING, I_TOOL_BUSY;
  logic I_BRAKE_HOLD_REQ, I_EXCITE_REQ, I_POWER_OK, I_AUTO_RETURN_COND;
  logic [15:0] I_REG_ADDR, I_REG_WDATA, I_CTRL_IN, I_SIG_OUT, O_CTRL_IN, O_SIG_OUT;
  logic [7:0] I_ALARM_ACTIVE, O_ALARM_CLEAR, clr_seen;
  logic [3:0] I_SENSOR_IN, O_SENSOR_IN;
  logic [2:0] O_DEFAULTS_KEEP;
  logic O_ALARM_HIST_CLEAR, O_WARN_HIST_CLEAR, O_COMM_HIST_CLEAR, O_POS_PRESET_LOAD;
  logic O_PARAM_RECALC, O_DEFAULTS_RESTORE, O_NVM_LOAD, O_NVM_STORE, O_CFG_BUSY;
  logic O_CFG_REFUSED, O_BRAKE_HOLD, O_EXCITE, O_POWER_INDICATOR, O_FAULT_INDICATOR;
  logic O_AUTO_RETURN_ALLOW;
  logic [8:0] pv;
  logic [1:0] ans;
  int pc[9] = '{default: 0};
  int pcs[9];
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Pulse counter that each command should bump; -1 for the alarm clears
  int ex[10] = '{-1, -1, 0, 1, 2, 3, 8, 5, 6, 7};

  mcr_maint_top i_mcr_maint_top (.I_MCLK, .I_RESET, .I_REG_WR, .I_REG_ADDR, .I_REG_WDATA,
    .O_REG_ACK, .O_REG_ERR, .I_ALARM_ACTIVE, .I_MOTOR_MOVING, .I_TOOL_BUSY, .I_BRAKE_HOLD_REQ,
    .I_EXCITE_REQ, .I_POWER_OK, .I_AUTO_RETURN_COND, .I_CTRL_IN, .I_SENSOR_IN, .I_SIG_OUT,
    .O_ALARM_CLEAR, .O_ALARM_HIST_CLEAR, .O_WARN_HIST_CLEAR, .O_COMM_HIST_CLEAR,
    .O_POS_PRESET_LOAD, .O_PARAM_RECALC, .O_DEFAULTS_RESTORE, .O_DEFAULTS_KEEP, .O_NVM_LOAD,
    .O_NVM_STORE, .O_CFG_BUSY, .O_CFG_REFUSED, .O_BRAKE_HOLD, .O_EXCITE, .O_POWER_INDICATOR,
    .O_FAULT_INDICATOR, .O_AUTO_RETURN_ALLOW, .O_CTRL_IN, .O_SENSOR_IN, .O_SIG_OUT);
  mcr_host_model i_mcr_host_model (.i_clk(I_MCLK), .i_ack(O_REG_ACK), .i_err(O_REG_ERR),
    .o_wr(I_REG_WR), .o_addr(I_REG_ADDR), .o_wdata(I_REG_WDATA));

  assign pv = {O_CFG_REFUSED, O_NVM_STORE, O_NVM_LOAD, O_DEFAULTS_RESTORE, O_PARAM_RECALC,
    O_POS_PRESET_LOAD, O_COMM_HIST_CLEAR, O_WARN_HIST_CLEAR, O_ALARM_HIST_CLEAR};

  initial begin
    I_MCLK = 1'b0;
    forever #4 I_MCLK = ~I_MCLK;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge I_MCLK) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      tally_and_finish();
    end
    for (int k = 0; k < 9; k++) begin
      if (pv[k] === 1'b1) pc[k]++;
    end
    if (O_ALARM_CLEAR !== 8'h00) clr_seen = clr_seen | O_ALARM_CLEAR;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic w(input logic [15:0] a, input logic [15:0] d, input logic [1:0] e);
    i_mcr_host_model.put_word(a, d, ans);
    check($sformatf("answer at %h", a), 16'(ans), 16'(e));
  endtask

  // Upper word 0 first, so the lower word alone decides the value
  task automatic cmd(input int c, input logic [15:0] v);
    w(ALARM_RESET_CMD_ADDR + 16'(2 * c), 16'h0000, 2'b10);
    w(ALARM_RESET_CMD_ADDR + 16'(2 * c + 1), v, 2'b10);
    repeat (4) @(negedge I_MCLK);
  endtask

  initial begin
    I_RESET = 1'b1;
    {I_MOTOR_MOVING, I_TOOL_BUSY, I_BRAKE_HOLD_REQ} = 3'h0;
    {I_EXCITE_REQ, I_POWER_OK, I_AUTO_RETURN_COND} = 3'h7;
    I_ALARM_ACTIVE = 8'hff;
    I_CTRL_IN = 16'h1234;
    I_SENSOR_IN = 4'h5;
    I_SIG_OUT = 16'h8001;
    clr_seen = 8'h00;
    repeat (16) @(negedge I_MCLK);
    I_RESET = 1'b0;
    repeat (4) @(negedge I_MCLK);
    check("keep mask", 16'(O_DEFAULTS_KEEP), 16'h0007);
    // Write 1, 1 again, then 0: only the first may act
    for (int c = 0; c < 10; c++) begin
      clr_seen = 8'h00;
      pcs = pc;
      cmd(c, 16'h0001);
      cmd(c, 16'h0001);
      cmd(c, 16'h0000);
      for (int k = 0; k < 9; k++) begin
        check($sformatf("cmd %0d pulse %0d", c, k), 16'(pc[k]),
          16'(pcs[k] + (ex[c] == k)));
      end
      check("alarm clear", 16'(clr_seen),
        c == 0 ? 16'h007e : c == 1 ? 16'h0001 : 16'h0000);
    end
    $display("test commands done");
    pcs = pc;
    w(16'h0194, 16'h0001, 2'b01);
    w(16'h017f, 16'h0001, 2'b01);
    w(16'h0193, 16'h0002, 2'b01);
    w(16'h0192, 16'h0001, 2'b10);
    w(16'h0193, 16'h0001, 2'b01);
    w(16'h0193, 16'h0001, 2'b10);
    w(16'h0193, 16'h0000, 2'b10);
    repeat (4) @(negedge I_MCLK);
    check("store count", 16'(pc[7]), 16'(pcs[7] + 1));
    $display("test refusals done");
    I_ALARM_ACTIVE = 8'h00;
    for (int p = 0; p < 2; p++) begin
      I_TOOL_BUSY = (p == 0);
      I_MOTOR_MOVING = (p == 1);
      repeat (4) @(negedge I_MCLK);
      pcs = pc;
      cmd(6, 16'h0001);
      check("refused busy", 16'({O_CFG_BUSY, O_EXCITE}), 16'h0001);
      cmd(6, 16'h0000);
      check("refusals", 16'(pc[8]), 16'(pcs[8] + 1));
      check("no recalc", 16'(pc[4]), 16'(pcs[4]));
    end
    I_MOTOR_MOVING = 1'b0;
    repeat (4) @(negedge I_MCLK);
    pcs = pc;
    cmd(6, 16'h0001);
    I_ALARM_ACTIVE = 8'h02;
    I_CTRL_IN = 16'h4321;
    repeat (4) @(negedge I_MCLK);
    check("held", 16'({O_CFG_BUSY, O_BRAKE_HOLD, O_EXCITE, O_POWER_INDICATOR,
      O_FAULT_INDICATOR}), 16'h001a);
    check("masked", O_CTRL_IN | 16'(O_SENSOR_IN), 16'h0000);
    // A fresh trigger while the setup runs must neither restart nor be refused
    cmd(6, 16'h0000);
    cmd(6, 16'h0001);
    check("no refusal", 16'(pc[8]), 16'(pcs[8]));
    I_ALARM_ACTIVE = 8'h00;
    for (int n = 0; n < 1400 && O_CFG_BUSY === 1'b1; n++) @(negedge I_MCLK);
    repeat (4) @(negedge I_MCLK);
    check("recalc", 16'(pc[4]), 16'(pcs[4] + 1));
    check("after", 16'({O_CFG_BUSY, O_BRAKE_HOLD, O_EXCITE, O_POWER_INDICATOR,
      O_FAULT_INDICATOR, O_AUTO_RETURN_ALLOW}), 16'h000c);
    check("ctrl back", O_CTRL_IN, 16'h4321);
    check("outs back", O_SIG_OUT, 16'h8001);
    check("sensor back", 16'(O_SENSOR_IN), 16'h0005);
    // Return move comes back once its condition has dropped and risen again
    I_AUTO_RETURN_COND = 1'b0;
    repeat (4) @(negedge I_MCLK);
    I_AUTO_RETURN_COND = 1'b1;
    repeat (4) @(negedge I_MCLK);
    check("return again", 16'(O_AUTO_RETURN_ALLOW), 16'h0001);
    $display("test configuration done");
    tally_and_finish();
  end
endmodule
